// >>> cpc_ctrl.sv
`timescale 1ns/100ps
// Function
// - Bits 0-3 are event flags, each cleared by writing one to it.
// - Bits 4-7 mask the four events onto the interrupt output.
// - Bit 8 makes port 1 reach the upper control half.
// - Bit 9 picks external frame syncs instead of the internal pulse.
// - Bit 10 drives the external flag output pin.
// - Bit 11 enables the serial port, else parallel companding.
// - Bit 12 enables the encoder on port 1 writes.
// - Bit 13 enables the decoder on port 1 reads.
// - Bit 14 picks A-law when set, mu-law when clear.
// - Bit 15 makes the serial clock an input; clear drives it out.
// - Frame pulse rate is serial clock rate over modulus plus two.
// - Bits 27-24 pick the master clock divide ratio for the serial clock.
// - Bit 28 widens the frame pulse from one to eight serial clocks.
// - Bit 29 picks two's-complement over sign-magnitude companding.
// - Bit 30 picks 16-bit coprocessor port; 8-bit uses half select.
// - Both mode pins low give coprocessor mode, else port 5 is generic.
// - Write strobe fall clears latch-empty; rise interrupts the processor.
// - Processor read of port 5 drops latch-empty and clears the latch.
// - Host read drives the latch out; strobe rise pulses poll, clears full in 16-bit mode or on the high byte.
module cpc_ctrl (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	input  wire cpc_pkg::cpc_io_req_type  io_req,
	output logic [15:0]                   io_rdata,
	output logic                          irq_out,
	output logic                          ext_flag_out,
	input  wire logic                     ext_irq_in_n,
	input  wire logic                     rx_frame_sync_in,
	input  wire logic                     tx_frame_sync_in,
	output logic                          int_frame_pulse,
	output logic                          xfer_frame,
	input  wire logic                     sclk_in,
	output logic                          sclk_out,
	output logic                          sclk_oe,
	output cpc_pkg::cpc_comp_cfg_type     comp_cfg,
	output logic                          p1_wr,
	output logic [15:0]                   p1_wdata,
	input  wire logic [15:0]              p1_rdata,
	output logic [15:0]                   gpio_out,
	input  wire logic [15:0]              gpio_in,
	input  wire logic                     coproc_mode_sel_a,
	input  wire logic                     coproc_mode_sel_b,
	input  wire cpc_pkg::cpc_host_type    host,
	output logic [15:0]                   host_data_out,
	output logic [1:0]                    host_data_oe,
	output logic                          rx_latch_empty,
	output logic                          tx_latch_full,
	output logic                          poll_input_n
);
	import cpc_pkg::*;

	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [15:0] rdata_ff, nxt_rdata;
	logic        irq_ff, nxt_irq;
	logic        p1_wr_ff, nxt_p1_wr;
	logic [15:0] p1_wdata_ff, nxt_p1_wdata;
	logic [15:0] gpio_ff, nxt_gpio;
	logic        exi_prev_ff, fsr_prev_ff, fsx_prev_ff, fr_prev_ff;
	logic [3:0]  ev;
	logic        coproc;
	logic        wr_fall, wr_rise, rd_fall, rd_rise, p5_rd;
	logic        fr_ff, nxt_fr;
	logic        wr_prev_ff, rd_prev_ff;
	logic [15:0] rx_latch_ff, nxt_rx_latch;
	logic        sclk_oe_ff, nxt_sclk_oe;

	// Mismatched mode pins are treated as not coprocessor
	assign coproc  = !coproc_mode_sel_a && !coproc_mode_sel_b;
	assign wr_fall = coproc && wr_prev_ff && !host.wr_n;
	assign wr_rise = coproc && !wr_prev_ff && host.wr_n;
	assign rd_fall = coproc && rd_prev_ff && !host.rd_n;
	assign rd_rise = coproc && !rd_prev_ff && host.rd_n;
	assign p5_rd   = io_req.rd && io_req.addr == CPC_PORT_COPROC && coproc;

	// External interrupt line is owned by the latch in coprocessor mode
	always_comb begin
		ev[0] = coproc ? wr_rise : (exi_prev_ff && !ext_irq_in_n);
		ev[1] = rx_frame_sync_in && !fsr_prev_ff;
		ev[2] = tx_frame_sync_in && !fsx_prev_ff;
		ev[3] = fr_ff && !fr_prev_ff;
	end

	always_comb begin
		nxt_ctrl     = ctrl_ff;
		nxt_rdata    = rdata_ff;
		nxt_p1_wr    = 1'b0;
		nxt_p1_wdata = p1_wdata_ff;
		nxt_gpio     = gpio_ff;
		if (io_req.wr && io_req.addr == CPC_PORT_CTRL) begin
			nxt_ctrl[15:4] = io_req.wdata[15:4];
			nxt_ctrl[3:0]  = ctrl_ff[3:0] & ~io_req.wdata[3:0];
		end
		if (io_req.wr && io_req.addr == CPC_PORT_AUX) begin
			if (ctrl_ff[CPC_B_P1SEL]) begin
				nxt_ctrl[31:16] = io_req.wdata & CPC_HI_WMASK;
			end else begin
				nxt_p1_wr    = 1'b1;
				nxt_p1_wdata = io_req.wdata;
			end
		end
		if (io_req.wr && io_req.addr == CPC_PORT_COPROC && !coproc) begin
			nxt_gpio = io_req.wdata;
		end
		// Set wins over a clear in the same cycle
		nxt_ctrl[3:0] = nxt_ctrl[3:0] | ev;
		if (io_req.rd) begin
			unique case (io_req.addr)
				CPC_PORT_CTRL: nxt_rdata = ctrl_ff[15:0];
				CPC_PORT_AUX: nxt_rdata = ctrl_ff[CPC_B_P1SEL] ? ctrl_ff[31:16] : p1_rdata;
				CPC_PORT_COPROC: nxt_rdata = coproc ? rx_latch_ff : gpio_in;
				default: nxt_rdata = 16'h0000;
			endcase
		end
		nxt_irq = |(ctrl_ff[3:0] & ctrl_ff[CPC_B_MASK +: 4]);
		// Taken from the next value so the pin turns with the write
		nxt_sclk_oe = !nxt_ctrl[CPC_B_SCLKIN];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_ff     <= CPC_CTRL_RST;
			rdata_ff    <= 16'h0000;
			irq_ff      <= 1'b0;
			p1_wr_ff    <= 1'b0;
			p1_wdata_ff <= 16'h0000;
			gpio_ff     <= 16'h0000;
			exi_prev_ff <= 1'b1;
			fsr_prev_ff <= 1'b0;
			fsx_prev_ff <= 1'b0;
			fr_prev_ff  <= 1'b0;
			sclk_oe_ff  <= 1'b1;
		end else begin
			ctrl_ff     <= nxt_ctrl;
			rdata_ff    <= nxt_rdata;
			irq_ff      <= nxt_irq;
			p1_wr_ff    <= nxt_p1_wr;
			p1_wdata_ff <= nxt_p1_wdata;
			gpio_ff     <= nxt_gpio;
			exi_prev_ff <= ext_irq_in_n;
			fsr_prev_ff <= rx_frame_sync_in;
			fsx_prev_ff <= tx_frame_sync_in;
			fr_prev_ff  <= fr_ff;
			sclk_oe_ff  <= nxt_sclk_oe;
		end
	end

	// Serial clock and frame counter
	logic [5:0] presc_ff, nxt_presc;
	logic       sclk_ff, nxt_sclk;
	logic       sclk_prev_ff;
	logic [8:0] fcnt_ff, nxt_fcnt;
	logic [3:0] fw_ff, nxt_fw;
	logic       xfr_ff, nxt_xfr;
	logic [5:0] half;
	logic       tick;

	always_comb begin
		half      = cpc_ratio(ctrl_ff[CPC_B_PRE +: 4]) >> 1;
		nxt_presc = presc_ff + 6'h01;
		nxt_sclk  = sclk_ff;
		if (presc_ff >= half - 6'h01) begin
			nxt_presc = 6'h00;
			nxt_sclk  = !sclk_ff;
		end
		// Both directions advance the frame counter on a rising clock
		tick = ctrl_ff[CPC_B_SCLKIN] ? (sclk_in && !sclk_prev_ff)
			: (nxt_sclk && !sclk_ff);
		nxt_fcnt = fcnt_ff;
		nxt_fr   = fr_ff;
		nxt_fw   = fw_ff;
		if (tick) begin
			if (fr_ff) begin
				if (fw_ff == 4'h0) begin
					nxt_fr = 1'b0;
				end else begin
					nxt_fw = fw_ff - 4'h1;
				end
			end
			if (fcnt_ff >= {1'b0, ctrl_ff[CPC_B_CNT +: 8]} + 9'h001) begin
				nxt_fcnt = 9'h000;
				nxt_fr   = 1'b1;
				nxt_fw   = ctrl_ff[CPC_B_FRW] ? CPC_FR_WIDE : 4'h0;
			end else begin
				nxt_fcnt = fcnt_ff + 9'h001;
			end
		end
		nxt_xfr = ctrl_ff[CPC_B_EXTFR] ? (tx_frame_sync_in || rx_frame_sync_in) : fr_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			presc_ff     <= 6'h00;
			sclk_ff      <= 1'b0;
			sclk_prev_ff <= 1'b0;
			fcnt_ff      <= 9'h000;
			fr_ff        <= 1'b0;
			fw_ff        <= 4'h0;
			xfr_ff       <= 1'b0;
		end else begin
			presc_ff     <= nxt_presc;
			sclk_ff      <= nxt_sclk;
			sclk_prev_ff <= sclk_in;
			fcnt_ff      <= nxt_fcnt;
			fr_ff        <= nxt_fr;
			fw_ff        <= nxt_fw;
			xfr_ff       <= nxt_xfr;
		end
	end

	// Coprocessor latches
	logic [15:0] tx_latch_ff, nxt_tx_latch;
	logic        rx_empty_ff, nxt_rx_empty;
	logic        tx_full_ff, nxt_tx_full;
	logic        poll_n_ff, nxt_poll_n;
	logic [1:0]  hoe_ff, nxt_hoe;
	logic [15:0] hout_ff, nxt_hout;
	logic        w16;

	always_comb begin
		w16          = ctrl_ff[CPC_B_W16];
		nxt_rx_latch = rx_latch_ff;
		nxt_tx_latch = tx_latch_ff;
		nxt_rx_empty = rx_empty_ff;
		nxt_tx_full  = tx_full_ff;
		nxt_poll_n   = 1'b1;
		nxt_hoe      = hoe_ff;
		nxt_hout     = hout_ff;
		if (wr_fall) begin
			nxt_rx_empty = 1'b0;
		end
		// Capture on the rising strobe, host holds data across it
		if (wr_rise) begin
			if (w16) begin
				nxt_rx_latch = host.data;
			end else if (host.byte_half_select) begin
				nxt_rx_latch[15:8] = host.data[7:0];
			end else begin
				nxt_rx_latch[7:0] = host.data[7:0];
			end
		end
		if (p5_rd) begin
			nxt_rx_empty = 1'b0;
			nxt_rx_latch = 16'h0000;
		end
		if (io_req.wr && io_req.addr == CPC_PORT_COPROC && coproc) begin
			nxt_tx_latch = io_req.wdata;
			nxt_tx_full  = 1'b1;
		end
		if (rd_fall) begin
			nxt_hoe  = w16 ? 2'b11 : 2'b01;
			nxt_hout = w16 ? tx_latch_ff
				: {8'h00, host.byte_half_select ? tx_latch_ff[15:8] : tx_latch_ff[7:0]};
		end
		// In 8-bit mode the word is done once the high byte is taken
		if (rd_rise) begin
			nxt_hoe    = 2'b00;
			nxt_poll_n = 1'b0;
			if (w16 || host.byte_half_select) begin
				nxt_tx_full = 1'b0;
			end
		end
		if (!coproc) begin
			nxt_hoe = 2'b00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_prev_ff  <= 1'b1;
			rd_prev_ff  <= 1'b1;
			rx_latch_ff <= 16'h0000;
			tx_latch_ff <= 16'h0000;
			rx_empty_ff <= 1'b1;
			tx_full_ff  <= 1'b0;
			poll_n_ff   <= 1'b1;
			hoe_ff      <= 2'b00;
			hout_ff     <= 16'h0000;
		end else begin
			wr_prev_ff  <= host.wr_n;
			rd_prev_ff  <= host.rd_n;
			rx_latch_ff <= nxt_rx_latch;
			tx_latch_ff <= nxt_tx_latch;
			rx_empty_ff <= nxt_rx_empty;
			tx_full_ff  <= nxt_tx_full;
			poll_n_ff   <= nxt_poll_n;
			hoe_ff      <= nxt_hoe;
			hout_ff     <= nxt_hout;
		end
	end

	assign io_rdata        = rdata_ff;
	assign irq_out         = irq_ff;
	assign ext_flag_out    = ctrl_ff[CPC_B_XF];
	assign int_frame_pulse = fr_ff;
	assign xfer_frame      = xfr_ff;
	assign sclk_out        = sclk_ff;
	assign sclk_oe         = sclk_oe_ff;
	assign comp_cfg        = {ctrl_ff[CPC_B_SEN], ctrl_ff[CPC_B_ENC], ctrl_ff[CPC_B_DEC],
		ctrl_ff[CPC_B_ALAW], ctrl_ff[CPC_B_TWOS]};
	assign p1_wr           = p1_wr_ff;
	assign p1_wdata        = p1_wdata_ff;
	assign gpio_out        = gpio_ff;
	assign host_data_out   = hout_ff;
	assign host_data_oe    = hoe_ff;
	assign rx_latch_empty  = rx_empty_ff;
	assign tx_latch_full   = tx_full_ff;
	assign poll_input_n    = poll_n_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_poll_pulse;
		!poll_input_n ##1 poll_input_n;
	endsequence

	property p_flag_clr;
		io_req.wr && io_req.addr == CPC_PORT_CTRL && io_req.wdata[1] && !ev[1] |=> !ctrl_ff[1];
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

	property p_flag_set;
		ev[2] |=> ctrl_ff[2];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag event lost");

	property p_irq;
		|(ctrl_ff[3:0] & ctrl_ff[7:4]) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("masked event gave no interrupt");

	property p_p1_hi;
		io_req.rd && io_req.addr == CPC_PORT_AUX && ctrl_ff[CPC_B_P1SEL] |=> io_rdata == $past(ctrl_ff[31:16]);
	endproperty
	a_p1_hi: assert property (p_p1_hi) else $error("port 1 upper half read wrong");

	property p_sclk_dir;
		sclk_oe == !ctrl_ff[CPC_B_SCLKIN];
	endproperty
	a_sclk_dir: assert property (p_sclk_dir) else $error("serial clock direction wrong");

	property p_fr_narrow;
		fr_ff && tick && fw_ff == 4'h0 && !ctrl_ff[CPC_B_FRW] |=> !fr_ff;
	endproperty
	a_fr_narrow: assert property (p_fr_narrow) else $error("frame pulse too long");

	property p_fr_bound;
		fcnt_ff <= {1'b0, ctrl_ff[CPC_B_CNT +: 8]} + 9'h001 || $changed(ctrl_ff[CPC_B_CNT +: 8]) ##1 1'b1;
	endproperty
	a_fr_bound: assert property (p_fr_bound) else $error("frame counter past modulus");

	property p_wr_fall;
		wr_fall |=> !rx_latch_empty;
	endproperty
	a_wr_fall: assert property (p_wr_fall) else $error("latch-empty not cleared");

	property p_wr_rise;
		wr_rise |=> ctrl_ff[0] ##1 (irq_out || !ctrl_ff[CPC_B_MASK]);
	endproperty
	a_wr_rise: assert property (p_wr_rise) else $error("write gave no interrupt flag");

	property p_p5_rd;
		p5_rd && !wr_rise |=> rx_latch_ff == 16'h0000 && !rx_latch_empty;
	endproperty
	a_p5_rd: assert property (p_p5_rd) else $error("latch not cleared on read");

	property p_rd_rise;
		rd_rise |=> s_poll_pulse;
	endproperty
	a_rd_rise: assert property (p_rd_rise) else $error("no poll pulse after host read");
endmodule : cpc_ctrl

// >>> cpc_pkg.sv
package cpc_pkg;
	localparam logic [2:0]  CPC_PORT_CTRL   = 3'h0;
	localparam logic [2:0]  CPC_PORT_AUX    = 3'h1;
	localparam logic [2:0]  CPC_PORT_COPROC = 3'h5;
	localparam int          CPC_B_MASK      = 4;
	localparam int          CPC_B_P1SEL     = 8;
	localparam int          CPC_B_EXTFR     = 9;
	localparam int          CPC_B_XF        = 10;
	localparam int          CPC_B_SEN       = 11;
	localparam int          CPC_B_ENC       = 12;
	localparam int          CPC_B_DEC       = 13;
	localparam int          CPC_B_ALAW      = 14;
	localparam int          CPC_B_SCLKIN    = 15;
	localparam int          CPC_B_CNT       = 16;
	localparam int          CPC_B_PRE       = 24;
	localparam int          CPC_B_FRW       = 28;
	localparam int          CPC_B_TWOS      = 29;
	localparam int          CPC_B_W16       = 30;
	localparam logic [31:0] CPC_CTRL_RST    = 32'h0000_0000;
	localparam logic [15:0] CPC_HI_WMASK    = 16'h7fff;
	localparam logic [3:0]  CPC_FR_WIDE     = 4'h7;
	localparam logic [5:0]  CPC_RATIO_DFLT  = 6'h20;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} cpc_io_req_type;

	typedef struct packed {
		logic        wr_n;
		logic        rd_n;
		logic        byte_half_select;
		logic [15:0] data;
	} cpc_host_type;

	typedef struct packed {
		logic ser_en;
		logic enc_en;
		logic dec_en;
		logic alaw;
		logic twos;
	} cpc_comp_cfg_type;

	function automatic logic [5:0] cpc_ratio(input logic [3:0] code);
		unique case (code)
			4'h0: cpc_ratio = 6'h20;
			4'h1: cpc_ratio = 6'h1c;
			4'h2: cpc_ratio = 6'h18;
			4'h4: cpc_ratio = 6'h14;
			4'h8: cpc_ratio = 6'h10;
			4'h9: cpc_ratio = 6'h0e;
			4'ha: cpc_ratio = 6'h0c;
			4'hc: cpc_ratio = 6'h0a;
			default: cpc_ratio = CPC_RATIO_DFLT;
		endcase
	endfunction : cpc_ratio
endpackage : cpc_pkg

// >>> cpc_host_model.sv
`timescale 1ns/100ps
module cpc_host_model (
	input  wire logic              ref_clk,
	output cpc_pkg::cpc_host_type  host
);
	import cpc_pkg::*;

	initial host = '{1'b1, 1'b1, 1'b0, 16'h0000};

	// Strobe low with data, then strobe high latches it
	task automatic wr(input logic hs, input logic [15:0] d);
		@(posedge ref_clk);
		host.wr_n <= 1'b0;
		host.byte_half_select <= hs;
		host.data <= d;
		repeat (3) @(posedge ref_clk);
		host.wr_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		host.data <= ~d; // Released bus must not look like held data
	endtask : wr

	// Read strobe low; device drives the latch until it rises
	task automatic rd_start(input logic hs);
		@(posedge ref_clk);
		host.rd_n <= 1'b0;
		host.byte_half_select <= hs;
	endtask : rd_start

	task automatic rd_end;
		@(posedge ref_clk);
		host.rd_n <= 1'b1;
	endtask : rd_end
endmodule : cpc_host_model

// >>> tb.sv
`timescale 1ns/100ps
module tb;
	import cpc_pkg::*;
	logic             ref_clk = 1'b0;
	logic             rst_n = 1'b0;
	cpc_io_req_type   io_req = '0;
	cpc_comp_cfg_type comp_cfg;
	cpc_host_type     host;
	logic [15:0]      io_rdata, p1_wdata, gpio_out, host_data_out, d;
	logic [1:0]       host_data_oe;
	logic             irq_out, ext_flag_out, int_frame_pulse, xfer_frame, sclk_out, sclk_oe, p1_wr;
	logic             rx_latch_empty, tx_latch_full, poll_input_n;
	logic             rx_fs = 1'b0, tx_fs = 1'b0, sclk_in = 1'b0, mode = 1'b1, ext_irq_n = 1'b1;
	int               errors = 0, compares = 0, k, div = 0;
	logic [3:0]       codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc};
	int               ratio [8] = '{32, 28, 24, 20, 16, 14, 12, 10};

	always #50 ref_clk = ~ref_clk;
	// External serial clock, period six cycles
	always @(posedge ref_clk) begin
		div <= (div == 2) ? 0 : div + 1;
		if (div == 2) begin
			sclk_in <= ~sclk_in;
		end
	end
	cpc_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
		.irq_out(irq_out), .ext_flag_out(ext_flag_out), .ext_irq_in_n(ext_irq_n),
		.rx_frame_sync_in(rx_fs), .tx_frame_sync_in(tx_fs), .int_frame_pulse(int_frame_pulse),
		.xfer_frame(xfer_frame), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.comp_cfg(comp_cfg), .p1_wr(p1_wr), .p1_wdata(p1_wdata), .p1_rdata(16'h1234),
		.gpio_out(gpio_out), .gpio_in(16'h00c3), .coproc_mode_sel_a(mode), .coproc_mode_sel_b(mode),
		.host(host), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.rx_latch_empty(rx_latch_empty), .tx_latch_full(tx_latch_full), .poll_input_n(poll_input_n));
	cpc_host_model host_m (.ref_clk(ref_clk), .host(host));

	task automatic tally_and_finish;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic io_wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		io_req <= '{1'b1, 1'b0, a, v};
		@(posedge ref_clk);
		io_req <= '0;
		#10;
	endtask : io_wr

	task automatic io_rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		io_req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge ref_clk);
		io_req <= '0;
		#10 v = io_rdata;
	endtask : io_rd

	// Cycles since the previous rise; the first call only finds phase
	task automatic rise(ref logic s, output int n);
		logic p;
		p = s;
		for (n = 1; n < 3000; n++) begin
			@(posedge ref_clk);
			#1;
			if (s === 1'b1 && p !== 1'b1) break;
			p = s;
		end
		if (n >= 3000) begin
			errors++;
			tally_and_finish;
		end
	endtask : rise

	task automatic high_len(ref logic s, output int n);
		for (n = 0; n < 3000 && s === 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (n >= 3000) begin
			errors++;
			tally_and_finish;
		end
	endtask : high_len

	task automatic hread(input logic hs, input logic [15:0] m, input logic [15:0] e, input logic [1:0] oe);
		host_m.rd_start(hs);
		repeat (3) @(posedge ref_clk);
		#10;
		chk(host_data_out & m, e);
		chk(host_data_oe, oe);
		host_m.rd_end;
		for (k = 0; k < 6 && poll_input_n !== 1'b0; k++) begin
			@(posedge ref_clk);
			#10;
		end
		chk(k < 6, 1);
		@(posedge ref_clk);
		#10 chk({poll_input_n, host_data_oe}, 3'b100);
	endtask : hread

	initial begin
		repeat (50000) @(posedge ref_clk);
		errors++;
		tally_and_finish;
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		#10 chk({rx_latch_empty, tx_latch_full, poll_input_n, sclk_oe, host_data_oe}, 6'b101100);
		io_rd(CPC_PORT_CTRL, d);
		chk(d, 16'h0000);
		io_wr(3'h3, 16'hffff);
		io_rd(3'h3, d);
		chk(d, 16'h0000);
		$display("test reset done");
		io_wr(CPC_PORT_CTRL, 16'h0020);
		@(posedge ref_clk);
		tx_fs <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#10 chk(irq_out, 0);
		@(posedge ref_clk);
		rx_fs <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#10 chk(irq_out, 1);
		io_rd(CPC_PORT_CTRL, d);
		chk(d & 16'h0007, 16'h0006);
		io_wr(CPC_PORT_CTRL, 16'h0026);
		io_rd(CPC_PORT_CTRL, d);
		chk(d & 16'h0007, 16'h0000);
		chk(irq_out, 0);
		@(posedge ref_clk);
		ext_irq_n <= 1'b0;
		io_rd(CPC_PORT_CTRL, d);
		chk(d & 16'h0001, 16'h0001);
		@(posedge ref_clk);
		ext_irq_n <= 1'b1;
		io_wr(CPC_PORT_CTRL, 16'h0001);
		io_rd(CPC_PORT_CTRL, d);
		chk(d & 16'h0001, 16'h0000);
		$display("test flags done");
		io_wr(CPC_PORT_CTRL, 16'h0500);
		chk(ext_flag_out, 1);
		io_wr(CPC_PORT_AUX, 16'h6808);
		io_rd(CPC_PORT_AUX, d);
		chk(d, 16'h6808);
		chk(comp_cfg.twos, 1);
		for (int i = 0; i < 8; i++) begin
			io_wr(CPC_PORT_AUX, {4'h6, codes[i], 8'h08});
			rise(sclk_out, k);
			rise(sclk_out, k);
			chk(k, ratio[i]);
		end
		rise(int_frame_pulse, k);
		rise(int_frame_pulse, k);
		chk(k, 100);
		high_len(int_frame_pulse, k);
		chk(k, 10);
		io_wr(CPC_PORT_AUX, 16'h7c08);
		rise(int_frame_pulse, k);
		high_len(int_frame_pulse, k);
		chk(k, 80);
		$display("test timing done");
		io_wr(CPC_PORT_CTRL, 16'h3800);
		chk({comp_cfg, ext_flag_out}, 6'h3a);
		io_wr(CPC_PORT_AUX, 16'ha5c3);
		chk({p1_wr, p1_wdata}, 17'h1a5c3);
		io_rd(CPC_PORT_AUX, d);
		chk(d, 16'h1234);
		io_wr(CPC_PORT_CTRL, 16'hb800);
		chk(sclk_oe, 0);
		rise(int_frame_pulse, k);
		rise(int_frame_pulse, k);
		chk(k, 60);
		io_wr(CPC_PORT_CTRL, 16'h4200);
		chk({comp_cfg.alaw, sclk_oe}, 2'b11);
		@(posedge ref_clk);
		rx_fs <= 1'b0;
		tx_fs <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#10 chk(xfer_frame, 0);
		@(posedge ref_clk);
		tx_fs <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#10 chk(xfer_frame, 1);
		io_rd(CPC_PORT_COPROC, d);
		chk(d, 16'h00c3);
		io_wr(CPC_PORT_COPROC, 16'h3c3c);
		chk(gpio_out, 16'h3c3c);
		$display("test port done");
		@(posedge ref_clk);
		mode <= 1'b0;
		io_wr(CPC_PORT_CTRL, 16'h0100);
		io_wr(CPC_PORT_AUX, 16'h4808);
		io_wr(CPC_PORT_CTRL, 16'h0010);
		host_m.wr(1'b0, 16'hbeef);
		repeat (3) @(posedge ref_clk);
		#10 chk({rx_latch_empty, irq_out}, 2'b01);
		io_rd(CPC_PORT_COPROC, d);
		chk(d, 16'hbeef);
		io_wr(CPC_PORT_CTRL, 16'h0011);
		@(posedge ref_clk);
		#10 chk({rx_latch_empty, irq_out}, 2'b00);
		io_wr(CPC_PORT_COPROC, 16'h5a3c);
		chk(tx_latch_full, 1);
		hread(1'b0, 16'hffff, 16'h5a3c, 2'b11);
		chk(tx_latch_full, 0);
		io_wr(CPC_PORT_CTRL, 16'h0100);
		io_wr(CPC_PORT_AUX, 16'h0808);
		io_wr(CPC_PORT_COPROC, 16'h5a3c);
		hread(1'b0, 16'h00ff, 16'h003c, 2'b01);
		chk(tx_latch_full, 1);
		hread(1'b1, 16'h00ff, 16'h005a, 2'b01);
		chk(tx_latch_full, 0);
		host_m.wr(1'b1, 16'h00a5);
		host_m.wr(1'b0, 16'h005a);
		io_rd(CPC_PORT_COPROC, d);
		chk(d, 16'ha55a);
		$display("test coprocessor done");
		tally_and_finish;
	end
endmodule : tb
